// >>> core/bpc_pkg.sv
// Package for the breakpoint control block: offsets, fields, resets.
package bpc_pkg;
  // ***************************************************************
  // Register byte addresses (offset index times four)
  // ***************************************************************
  localparam int BPC_IDX_CTRL2 = 32'h00000028;
  localparam int BPC_IDX_CTRL3 = 32'h00000029;
  localparam logic [11:0] BPC_ADDR_CTRL2 = 12'h0a0;
  localparam logic [11:0] BPC_ADDR_CTRL3 = 12'h0a4;
  localparam logic [11:0] BPC_ADDR_TRACE = 12'h0a8;
  localparam logic [11:0] BPC_ADDR_COMPA = 12'h0ac;
  localparam logic [11:0] BPC_ADDR_COMPB = 12'h0b0;
  localparam logic [11:0] BPC_ADDR_COMPC = 12'h0b4;
  localparam logic [11:0] BPC_ADDR_STAT = 12'h0b8;
  // ***************************************************************
  // Control two fields
  // ***************************************************************
  localparam int BPC_C2_PAIR_EN = 7;
  localparam int BPC_C2_FULL = 6;
  localparam int BPC_C2_HALT = 5;
  localparam int BPC_C2_TAG_AB = 4;
  localparam int BPC_C2_C_EN = 3;
  localparam int BPC_C2_TAG_C = 2;
  localparam int BPC_C2_DIR_EN = 1;
  localparam int BPC_C2_DIR_VAL = 0;
  // ***************************************************************
  // Control three fields
  // ***************************************************************
  localparam int BPC_C3_AMH = 7;
  localparam int BPC_C3_AML = 6;
  localparam int BPC_C3_BMH = 5;
  localparam int BPC_C3_BML = 4;
  localparam int BPC_C3_DIR_A_EN = 3;
  localparam int BPC_C3_DIR_A_VAL = 2;
  localparam int BPC_C3_DIR_B_EN = 1;
  localparam int BPC_C3_DIR_B_VAL = 0;
  // ***************************************************************
  // Trace control fields (own register)
  // ***************************************************************
  localparam int BPC_TR_ENABLE = 0;
  localparam int BPC_TR_LOOP = 1;
  localparam int BPC_TR_ARM = 2;
  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] BPC_RST_CTRL2 = 8'h00;
  localparam logic [7:0] BPC_RST_CTRL3 = 8'h00;
  localparam logic [2:0] BPC_RST_TRACE = 3'h0;
  localparam logic [21:0] BPC_RST_COMP = 22'h000000;
  // Comparator value layout: ext[21:16], high[15:8], low[7:0]
  localparam int BPC_EXT_W = 6;
  localparam int BPC_ADDR_W = 16;
endpackage : bpc_pkg

// >>> core/bpc_match.sv
// Address comparator with byte masks and optional program page.
`timescale 1ns/1ps
module bpc_match
  import bpc_pkg::*;
(
  input wire logic [21:0] comp,
  input wire logic [5:0] page,
  input wire logic page_sel,
  input wire logic [15:0] addr,
  input wire logic mask_high,
  input wire logic mask_low,
  output logic hit
);
  logic eff_high;
  logic ext_ok;
  logic hi_ok;
  logic lo_ok;
  always_comb begin
    // Low unmasked: full compare, high mask ignored
    eff_high = mask_high & mask_low;
    ext_ok = !page_sel || (comp[21:16] == page);
    if (page_sel) begin
      hi_ok = comp[13:8] == addr[13:8];
    end else begin
      hi_ok = comp[15:8] == addr[15:8];
    end
    lo_ok = comp[7:0] == addr[7:0];
    hit = ext_ok && (eff_high || hi_ok) && (mask_low || lo_ok);
    if (mask_high && mask_low) begin
      hit = page_sel && (comp[21:16] == page);
    end
  end
endmodule : bpc_match

// >>> core/bpc_top.sv
// Breakpoint control unit with APB registers and break request logic.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module bpc_top
  import bpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_data,
  input wire logic cpu_read,
  input wire logic cpu_valid,
  input wire logic page_sel,
  input wire logic [5:0] page_value,
  input wire logic opcode_fetch,
  input wire logic opcode_execute,
  input wire logic instr_boundary,
  output logic software_interrupt,
  output logic background_halt
);
  // *****************************************************************
  // Register file
  // *****************************************************************
  logic [7:0] ctrl2_q;
  logic [7:0] ctrl3_q;
  logic [2:0] trace_q;
  logic [21:0] comp_a_q;
  logic [21:0] comp_b_q;
  logic [21:0] comp_c_q;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic loop_arm;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      BPC_ADDR_CTRL2, BPC_ADDR_CTRL3, BPC_ADDR_TRACE, BPC_ADDR_COMPA,
      BPC_ADDR_COMPB, BPC_ADDR_COMPC, BPC_ADDR_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;
  // Arming in single loop mode
  assign loop_arm = wr_en && (paddr == BPC_ADDR_TRACE) &&
    pwdata[BPC_TR_ARM] && pwdata[BPC_TR_LOOP];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2_q <= BPC_RST_CTRL2;
    end else if (wr_en && paddr == BPC_ADDR_CTRL2) begin
      ctrl2_q <= pwdata[7:0];
      if (loop_arm || trace_q[BPC_TR_LOOP]) begin
        ctrl2_q[BPC_C2_C_EN] <= 1'b0;
      end
    end else if (loop_arm) begin
      ctrl2_q[BPC_C2_C_EN] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl3_q <= BPC_RST_CTRL3;
    end else if (wr_en && paddr == BPC_ADDR_CTRL3) begin
      ctrl3_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_q <= BPC_RST_TRACE;
    end else if (wr_en && paddr == BPC_ADDR_TRACE) begin
      trace_q <= pwdata[2:0];
      if (ctrl2_q[BPC_C2_PAIR_EN]) begin
        trace_q[BPC_TR_ENABLE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_a_q <= BPC_RST_COMP;
      comp_b_q <= BPC_RST_COMP;
      comp_c_q <= BPC_RST_COMP;
    end else if (wr_en) begin
      if (paddr == BPC_ADDR_COMPA) begin
        comp_a_q <= pwdata[21:0];
      end
      if (paddr == BPC_ADDR_COMPB) begin
        comp_b_q <= pwdata[21:0];
      end
      if (paddr == BPC_ADDR_COMPC) begin
        comp_c_q <= pwdata[21:0];
      end
    end
  end

  // *****************************************************************
  // Mode decode
  // *****************************************************************
  logic pair_on;
  logic trace_mode;
  logic full_mode;
  logic pair_tag;
  logic third_on;
  logic amh;
  logic aml;
  assign pair_on = ctrl2_q[BPC_C2_PAIR_EN];
  assign trace_mode = !pair_on && trace_q[BPC_TR_ENABLE];
  assign full_mode = ctrl2_q[BPC_C2_FULL] && !trace_mode;
  assign pair_tag = ctrl2_q[BPC_C2_TAG_AB] && !trace_mode;
  assign third_on = ctrl2_q[BPC_C2_C_EN] && !trace_q[BPC_TR_LOOP];
  assign amh = ctrl3_q[BPC_C3_AMH] && !trace_mode;
  assign aml = ctrl3_q[BPC_C3_AML] && !trace_mode;

  // *****************************************************************
  // Comparators
  // *****************************************************************
  logic hit_a;
  logic hit_b_addr;
  logic hit_c_addr;
  logic hit_data;
  logic hit_ab;
  logic hit_c;
  logic dir_a_ok;
  logic dir_b_ok;
  logic dir_c_ok;
  logic bmh;
  logic bml;

  bpc_match u_match_a (
    .comp(comp_a_q), .page(page_value), .page_sel(page_sel),
    .addr(cpu_addr), .mask_high(amh), .mask_low(aml), .hit(hit_a)
  );
  bpc_match u_match_b (
    .comp(comp_b_q), .page(page_value), .page_sel(page_sel),
    .addr(cpu_addr), .mask_high(ctrl3_q[BPC_C3_BMH]),
    .mask_low(ctrl3_q[BPC_C3_BML]), .hit(hit_b_addr)
  );
  bpc_match u_match_c (
    .comp(comp_c_q), .page(page_value), .page_sel(page_sel),
    .addr(cpu_addr), .mask_high(1'b0), .mask_low(1'b0), .hit(hit_c_addr)
  );

  // Data compare selected by second masks in full mode
  always_comb begin
    bmh = ctrl3_q[BPC_C3_BMH];
    bml = ctrl3_q[BPC_C3_BML];
    hit_data = (bmh || comp_b_q[15:8] == cpu_data[15:8]) &&
      (bml || comp_b_q[7:0] == cpu_data[7:0]);
  end

  // Direction qualification per comparator
  always_comb begin
    dir_a_ok = !ctrl3_q[BPC_C3_DIR_A_EN] ||
      (cpu_read == ctrl3_q[BPC_C3_DIR_A_VAL]);
    dir_b_ok = !ctrl3_q[BPC_C3_DIR_B_EN] ||
      (cpu_read == ctrl3_q[BPC_C3_DIR_B_VAL]);
    dir_c_ok = !ctrl2_q[BPC_C2_DIR_EN] ||
      (cpu_read == ctrl2_q[BPC_C2_DIR_VAL]);
  end

  always_comb begin
    if (full_mode) begin
      hit_ab = hit_a && dir_a_ok && hit_data;
    end else begin
      hit_ab = (hit_a && dir_a_ok) || (hit_b_addr && dir_b_ok);
    end
    hit_ab = hit_ab && cpu_valid && pair_on;
    hit_c = hit_c_addr && dir_c_ok && cpu_valid && third_on;
  end

  // *****************************************************************
  // Break request generation
  // *****************************************************************
  logic force_pend_q;
  logic tag_pend_q;
  logic tag_hit;
  logic force_hit;
  logic fire;
  logic c_tag;
  assign c_tag = ctrl2_q[BPC_C2_TAG_C];
  // Tag only on opcode fetch
  assign tag_hit = opcode_fetch &&
    ((hit_ab && pair_tag) || (hit_c && c_tag));
  assign force_hit = (hit_ab && !pair_tag) ||
    (hit_c && !c_tag);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_pend_q <= 1'b0;
    end else if (force_pend_q && instr_boundary) begin
      force_pend_q <= force_hit;
    end else if (force_hit) begin
      force_pend_q <= 1'b1;
    end
  end

  // Tag consumed by execution, dropped if flushed without it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_pend_q <= 1'b0;
    end else if (tag_hit) begin
      tag_pend_q <= 1'b1;
    end else if (instr_boundary || opcode_execute) begin
      tag_pend_q <= 1'b0;
    end
  end

  assign fire = (force_pend_q && instr_boundary) ||
    (tag_pend_q && opcode_execute);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      software_interrupt <= 1'b0;
      background_halt <= 1'b0;
    end else begin
      software_interrupt <= fire && !ctrl2_q[BPC_C2_HALT];
      background_halt <= fire && ctrl2_q[BPC_C2_HALT];
    end
  end

  // *****************************************************************
  // Read data
  // *****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        BPC_ADDR_CTRL2: prdata <= {24'h000000, ctrl2_q};
        BPC_ADDR_CTRL3: prdata <= {24'h000000, ctrl3_q};
        BPC_ADDR_TRACE: prdata <= {29'h00000000, trace_q};
        BPC_ADDR_COMPA: prdata <= {10'h000, comp_a_q};
        BPC_ADDR_COMPB: prdata <= {10'h000, comp_b_q};
        BPC_ADDR_COMPC: prdata <= {10'h000, comp_c_q};
        BPC_ADDR_STAT: prdata <= {28'h0000000, trace_mode, full_mode,
          tag_pend_q, force_pend_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  // Unused read strobe kept for clarity of decode
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule : bpc_top

// >>> tb/bpc_assertions.sv
// Port checker for the breakpoint control block.
`timescale 1ns/1ps
module bpc_chk
  import bpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic opcode_execute,
  input wire logic instr_boundary,
  input wire logic software_interrupt,
  input wire logic background_halt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, mapd;
  assign acc = psel && penable;
  assign mapd = paddr inside {BPC_ADDR_CTRL2, BPC_ADDR_CTRL3,
    BPC_ADDR_TRACE, BPC_ADDR_COMPA, BPC_ADDR_COMPB, BPC_ADDR_COMPC,
    BPC_ADDR_STAT};
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc && !mapd |-> pslverr)
    else $error("no error on unmapped access");
  a_ok_mapped: assert property (acc && mapd |-> !pslverr)
    else $error("error on mapped access");
  a_zero_unmapped: assert property (
    acc && !pwrite && !mapd |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_swi_pulse: assert property (
    software_interrupt |=> !software_interrupt)
    else $error("interrupt request too long");
  a_halt_pulse: assert property (
    background_halt |=> !background_halt)
    else $error("halt request too long");
  a_single_action: assert property (
    !(software_interrupt && background_halt))
    else $error("both break actions at once");
  a_break_cause: assert property (
    $rose(software_interrupt) || $rose(background_halt) |->
    $past(instr_boundary) || $past(opcode_execute))
    else $error("break without boundary or execute");
endmodule : bpc_chk
bind bpc_top bpc_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .opcode_execute, .instr_boundary,
  .software_interrupt, .background_halt);

// >>> tb/bpc_cpu.sv
// CPU core model: one bus cycle, then a boundary or execute strobe.
`timescale 1ns/1ps
module bpc_cpu
  import bpc_pkg::*;
(
  input wire logic pclk,
  input wire logic software_interrupt,
  input wire logic background_halt,
  output logic [15:0] cpu_addr,
  output logic [15:0] cpu_data,
  output logic cpu_read,
  output logic cpu_valid,
  output logic page_sel,
  output logic [5:0] page_value,
  output logic opcode_fetch,
  output logic opcode_execute,
  output logic instr_boundary
);
  initial begin
    {cpu_addr, cpu_data, cpu_read, cpu_valid, page_sel} = '0;
    {page_value, opcode_fetch, opcode_execute, instr_boundary} = '0;
  end
  task cyc(input logic [15:0] a, input logic [15:0] d, input logic r,
    input logic ps, input logic [5:0] pg, input logic f, input logic x,
    output int ns, output int nh);
    @(posedge pclk);
    {cpu_addr, cpu_data, cpu_read, cpu_valid} <= {a, d, r, 1'b1};
    {page_sel, page_value, opcode_fetch} <= {ps, pg, f};
    @(posedge pclk);
    // Released bus shows the inverse of its last value
    {cpu_addr, cpu_data, cpu_valid, opcode_fetch} <= {~a, ~d, 2'b00};
    @(posedge pclk);
    {opcode_execute, instr_boundary} <= {x, !x};
    @(posedge pclk);
    {opcode_execute, instr_boundary} <= 2'b00;
    ns = 0;
    nh = 0;
    repeat (4) begin
      #1;
      ns += int'(software_interrupt === 1'b1);
      nh += int'(background_halt === 1'b1);
      @(posedge pclk);
    end
  endtask : cyc
endmodule : bpc_cpu

// >>> tb/testbench.sv
// Self-checking testbench of the breakpoint control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench
  import bpc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, rnd;
  logic [15:0] cpu_addr, cpu_data, a, d;
  logic [5:0] page_value, pg;
  logic cpu_read, cpu_valid, page_sel, opcode_fetch, opcode_execute;
  logic instr_boundary, software_interrupt, background_halt, ps, ex;
  logic [21:0] ca, cb;
  logic [4:0] m;
  int err_count = 0;
  int cmp_count = 0;
  int ns, nh;
  bpc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_addr, .cpu_data, .cpu_read,
    .cpu_valid, .page_sel, .page_value, .opcode_fetch, .opcode_execute,
    .instr_boundary, .software_interrupt, .background_halt);
  bpc_cpu i_cpu (.pclk, .software_interrupt, .background_halt, .cpu_addr,
    .cpu_data, .cpu_read, .cpu_valid, .page_sel, .page_value,
    .opcode_fetch, .opcode_execute, .instr_boundary);
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function logic ahit(input logic [21:0] c, input logic [15:0] x,
    input logic p, input logic [5:0] g, input logic mh, input logic ml);
    logic e, h, l;
    e = !p || c[21:16] == g;
    h = p ? c[13:8] == x[13:8] : c[15:8] == x[15:8];
    l = c[7:0] == x[7:0];
    if (!ml) return e && h && l;
    return e && (mh || h);
  endfunction : ahit
  function logic dhit(input logic [21:0] c, input logic [15:0] x,
    input logic mh, input logic ml);
    return (mh || c[15:8] == x[15:8]) && (ml || c[7:0] == x[7:0]);
  endfunction : dhit
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task results;
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #1000000;
    err_count++;
    results();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    rnd = 32'h6516e730;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, BPC_ADDR_CTRL2, 0);
    `CHK("ctrl2 reset", BPC_RST_CTRL2, rdat[7:0])
    apb(0, BPC_ADDR_CTRL3, 0);
    `CHK("ctrl3 reset", BPC_RST_CTRL3, rdat[7:0])
    apb(1, 12'h0c0, 32'hff);
    `CHK("unmapped err", 1'b1, rerr)
    apb(0, 12'h0c0, 0);
    `CHK("unmapped read", 32'h0, rdat)
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      apb(1, i[0] ? BPC_ADDR_CTRL3 : BPC_ADDR_CTRL2, rnd);
      apb(0, i[0] ? BPC_ADDR_CTRL3 : BPC_ADDR_CTRL2, 0);
      `CHK("ctrl readback", rnd[7:0], rdat[7:0])
    end
    apb(1, BPC_ADDR_CTRL2, 32'h80);
    apb(1, BPC_ADDR_TRACE, 32'h1);
    apb(0, BPC_ADDR_TRACE, 0);
    `CHK("trace blocked", 1'b0, rdat[BPC_TR_ENABLE])
    apb(1, BPC_ADDR_CTRL2, 32'h0);
    apb(1, BPC_ADDR_TRACE, 32'h1);
    apb(0, BPC_ADDR_TRACE, 0);
    `CHK("trace set", 1'b1, rdat[BPC_TR_ENABLE])
    apb(1, BPC_ADDR_CTRL2, 32'h8);
    apb(1, BPC_ADDR_TRACE, 32'h6);
    apb(0, BPC_ADDR_CTRL2, 0);
    `CHK("third enable", 1'b0, rdat[BPC_C2_C_EN])
    apb(1, BPC_ADDR_TRACE, 32'h0);
    for (int i = 0; i < 48; i++) begin
      rnd = lfsr(rnd);
      ca = rnd[21:0];
      m = rnd[26:22];
      apb(1, BPC_ADDR_COMPA, {10'h0, ca});
      rnd = lfsr(rnd);
      cb = rnd[21:0];
      apb(1, BPC_ADDR_COMPB, {10'h0, cb});
      apb(1, BPC_ADDR_CTRL3, {24'h0, m[1:0], m[3:2], 4'h0});
      apb(1, BPC_ADDR_CTRL2, {24'h0, 2'b11, m[4], 5'h0});
      rnd = lfsr(rnd);
      a = ca[15:0] ^ (rnd[15:0] & {{2{rnd[16]}}, {6{rnd[17]}}, {8{rnd[18]}}});
      pg = ca[21:16] ^ (rnd[24:19] & {6{rnd[25]}});
      ps = rnd[26] || (m[1] && m[0]);
      d = cb[15:0] ^ (rnd[15:0] & {{8{rnd[27]}}, {8{rnd[28]}}});
      ex = ahit(ca, a, ps, pg, m[1], m[0]) && dhit(cb, d, m[3], m[2]);
      i_cpu.cyc(a, d, rnd[29], ps, pg, 1'b0, 1'b0, ns, nh);
      `CHK("swi count", int'(ex && !m[4]), ns)
      `CHK("halt count", int'(ex && m[4]), nh)
    end
    apb(1, BPC_ADDR_COMPA, 32'h123);
    apb(1, BPC_ADDR_CTRL3, 32'h30);
    apb(1, BPC_ADDR_CTRL2, 32'hd0);
    i_cpu.cyc(16'h0123, 0, 1, 0, 0, 1, 1, ns, nh);
    `CHK("tag exec", 1, ns)
    i_cpu.cyc(16'h0123, 0, 1, 0, 0, 1, 0, ns, nh);
    `CHK("tag unexec", 0, ns)
    i_cpu.cyc(16'h0999, 0, 1, 0, 0, 1, 1, ns, nh);
    `CHK("tag flushed", 0, ns)
    apb(1, BPC_ADDR_CTRL3, 0);
    apb(1, BPC_ADDR_COMPA, 32'h3fffff);
    apb(1, BPC_ADDR_COMPC, 32'h456);
    for (int k = 0; k < 8; k++) begin
      apb(1, BPC_ADDR_CTRL2, {24'h0, 6'b110010, k[1:0]});
      i_cpu.cyc(16'h0456, 0, k[2], 0, 0, 0, 0, ns, nh);
      `CHK("third dir", int'(!k[1] || k[0] == k[2]), ns)
    end
    apb(1, BPC_ADDR_CTRL2, 32'hc0);
    i_cpu.cyc(16'h0456, 0, 0, 0, 0, 0, 0, ns, nh);
    `CHK("third off", 0, ns)
    apb(1, BPC_ADDR_CTRL2, 32'hcc);
    i_cpu.cyc(16'h0456, 0, 1, 0, 0, 1, 1, ns, nh);
    `CHK("third tag exec", 1, ns)
    i_cpu.cyc(16'h0456, 0, 1, 0, 0, 1, 0, ns, nh);
    `CHK("third tag unexec", 0, ns)
    apb(1, BPC_ADDR_CTRL2, 32'h48);
    apb(1, BPC_ADDR_TRACE, 32'h1);
    apb(0, BPC_ADDR_STAT, 0);
    `CHK("trace status", 4'h8, rdat[3:0])
    i_cpu.cyc(16'h0456, 0, 0, 0, 0, 0, 0, ns, nh);
    `CHK("trace third", 1, ns)
    apb(1, BPC_ADDR_TRACE, 32'h3);
    i_cpu.cyc(16'h0456, 0, 0, 0, 0, 0, 0, ns, nh);
    `CHK("loop third", 0, ns)
    results();
  end
endmodule : testbench
